// >>> logic/irq_route_pkg.sv
// Shared constants and types for the interrupt enable and pin routing block
package irq_route_pkg;
  localparam logic [7:0] ENABLES_OFFSET = 8'h2d;
  localparam logic [7:0] ROUTING_OFFSET = 8'h2e;
  localparam logic [7:0] SOURCE_OFFSET  = 8'h0c;
  localparam logic [7:0] ENABLES_RESET  = 8'h00;
  localparam logic [7:0] ROUTING_RESET  = 8'h00;
  localparam logic [7:0] USED_BITS_MASK = 8'hfd;
  localparam int         BIT_SLEEP_WAKE = 7;
  localparam int         BIT_FIFO       = 6;
  localparam int         BIT_JOLT       = 5;
  localparam int         BIT_TILT       = 4;
  localparam int         BIT_PULSE      = 3;
  localparam int         BIT_FALL_MOVE  = 2;
  localparam int         BIT_UNUSED     = 1;
  localparam int         BIT_SAMPLE_RDY = 0;
  localparam logic       STAGE_PUSH_PULL  = 1'b0;
  localparam logic       STAGE_OPEN_DRAIN = 1'b1;
  localparam logic       POLARITY_LOW     = 1'b0;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic o;
    logic oe_b;
  } pin_drive_t;
endpackage

// >>> logic/irq_pin_driver.sv
// Output stage for one interrupt pin: polarity and push-pull or open-drain
`timescale 1ns/1ps
module irq_pin_driver
  import irq_route_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       active,
  input  wire logic       output_stage_select,
  input  wire logic       irq_level_polarity,
  output pin_drive_t      drive
);
  logic level;

  always_comb begin
    level = active ^ (irq_level_polarity == POLARITY_LOW);
  end

  // Open-drain only pulls low; the high level is left to the shared pull-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive <= '{o: 1'b1, oe_b: 1'b0};
    end else if (output_stage_select == STAGE_OPEN_DRAIN) begin
      drive <= '{o: 1'b0, oe_b: level};
    end else begin
      drive <= '{o: level, oe_b: 1'b0};
    end
  end
endmodule

// >>> logic/motion_interrupt_routing.sv
// Interrupt enable, pin routing and source reporting for the motion sensor
//
// Contract
// - Both pins are push-pull when the output stage select is 0 and open-drain when it is 1; in reset both drive high push-pull.
// - The enable register at 0x2d holds one enable per source, bit 1 unused and reading 0.
// - Every enable resets to 0 (disabled) and writing 1 enables that source.
// - A source event flag reaches the controller only while its enable bit is set.
// - The routing register at 0x2e uses the same bit layout, bit 1 unused and reading 0.
// - A routing bit of 0 sends the source to pin b and a 1 sends it to pin a.
// - Pins signal an event low when polarity is 0 and high when polarity is 1; reset holds both pins driven high.
`timescale 1ns/1ps
module motion_interrupt_routing
  import irq_route_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  reg_req_t        reg_req,
  output logic [7:0]      reg_rdata,
  input  wire logic [7:0] event_flags,
  input  wire logic       output_stage_select,
  input  wire logic       irq_level_polarity,
  output logic            irq_pin_a_o,
  output logic            irq_pin_a_oe_b,
  output logic            irq_pin_b_o,
  output logic            irq_pin_b_oe_b
);
  logic [7:0] enables_q;
  logic [7:0] routing_q;
  logic [7:0] pending;
  logic       pin_a_active;
  logic       pin_b_active;
  pin_drive_t drive_a;
  pin_drive_t drive_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enables_q <= ENABLES_RESET;
    end else if (reg_req.wr && reg_req.addr == ENABLES_OFFSET) begin
      enables_q <= reg_req.wdata & USED_BITS_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      routing_q <= ROUTING_RESET;
    end else if (reg_req.wr && reg_req.addr == ROUTING_OFFSET) begin
      routing_q <= reg_req.wdata & USED_BITS_MASK;
    end
  end

  always_comb begin
    pending      = event_flags & enables_q & USED_BITS_MASK;
    pin_a_active = |(pending & routing_q);
    pin_b_active = |(pending & ~routing_q);
  end

  // Read data is registered so the bus sees a one-cycle read latency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_req.addr)
        ENABLES_OFFSET: reg_rdata <= enables_q;
        ROUTING_OFFSET: reg_rdata <= routing_q;
        SOURCE_OFFSET:  reg_rdata <= pending;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  irq_pin_driver u_drv_a (
    .clk                 (clk),
    .rst_b               (rst_b),
    .active              (pin_a_active),
    .output_stage_select (output_stage_select),
    .irq_level_polarity  (irq_level_polarity),
    .drive               (drive_a)
  );

  irq_pin_driver u_drv_b (
    .clk                 (clk),
    .rst_b               (rst_b),
    .active              (pin_b_active),
    .output_stage_select (output_stage_select),
    .irq_level_polarity  (irq_level_polarity),
    .drive               (drive_b)
  );

  always_comb begin
    irq_pin_a_o    = drive_a.o;
    irq_pin_a_oe_b = drive_a.oe_b;
    irq_pin_b_o    = drive_b.o;
    irq_pin_b_oe_b = drive_b.oe_b;
  end

  // Pin level as seen by the host, with a pull-up when released
  logic wire_a;
  logic wire_b;
  always_comb begin
    wire_a = irq_pin_a_oe_b ? 1'b1 : irq_pin_a_o;
    wire_b = irq_pin_b_oe_b ? 1'b1 : irq_pin_b_o;
  end

  // Pin levels lag polarity by one flop, so checks compare against the previous polarity

  sequence write_enables_s;
    reg_req.wr && reg_req.addr == ENABLES_OFFSET;
  endsequence

  sequence write_routing_s;
    reg_req.wr && reg_req.addr == ROUTING_OFFSET;
  endsequence

  sequence no_enable_write_s;
    !(reg_req.wr && reg_req.addr == ENABLES_OFFSET);
  endsequence

  sequence no_routing_write_s;
    !(reg_req.wr && reg_req.addr == ROUTING_OFFSET);
  endsequence

  sequence unmapped_read_s;
    reg_req.addr != ENABLES_OFFSET && reg_req.addr != ROUTING_OFFSET
      && reg_req.addr != SOURCE_OFFSET;
  endsequence

  enable_reset_a: assert property (
    @(posedge clk) $rose(rst_b) |-> enables_q == ENABLES_RESET)
    else $error("enables not cleared by reset");

  routing_reset_a: assert property (
    @(posedge clk) $rose(rst_b) |-> routing_q == ROUTING_RESET)
    else $error("routing not cleared by reset");

  pin_reset_a: assert property (
    @(posedge clk) $rose(rst_b) |-> irq_pin_a_o && !irq_pin_a_oe_b
      && irq_pin_b_o && !irq_pin_b_oe_b)
    else $error("pins not idle after reset");

  enable_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    write_enables_s |=> enables_q == ($past(reg_req.wdata) & USED_BITS_MASK))
    else $error("enable write not stored");

  routing_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    write_routing_s |=> routing_q == ($past(reg_req.wdata) & USED_BITS_MASK))
    else $error("routing write not stored");

  enable_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    no_enable_write_s |=> $stable(enables_q))
    else $error("enables changed without a write");

  routing_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    no_routing_write_s |=> $stable(routing_q))
    else $error("routing changed without a write");

  routing_bit1_a: assert property (@(posedge clk) disable iff (!rst_b)
    routing_q[BIT_UNUSED] == 1'b0 && enables_q[BIT_UNUSED] == 1'b0)
    else $error("unused bit 1 set");

  gate_disabled_a: assert property (@(posedge clk) disable iff (!rst_b)
    enables_q == ENABLES_RESET ##1 enables_q == ENABLES_RESET
      |-> wire_a != $past(irq_level_polarity))
    else $error("pin a asserted with no source enabled");

  route_pin_a_a: assert property (@(posedge clk) disable iff (!rst_b)
    |(event_flags & enables_q & routing_q & USED_BITS_MASK)
      |=> wire_a == $past(irq_level_polarity))
    else $error("routed source missing on pin a");

  route_pin_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    |(event_flags & enables_q & ~routing_q & USED_BITS_MASK)
      |=> wire_b == $past(irq_level_polarity))
    else $error("routed source missing on pin b");

  release_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(|(event_flags & enables_q & USED_BITS_MASK))
      |=> wire_a != $past(irq_level_polarity) && wire_b != $past(irq_level_polarity))
    else $error("pin held with nothing pending");

  release_pin_a_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pin_a_active |=> wire_a != $past(irq_level_polarity))
    else $error("pin a held with nothing routed to it");

  release_pin_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pin_b_active |=> wire_b != $past(irq_level_polarity))
    else $error("pin b held with nothing routed to it");

  open_drain_a: assert property (@(posedge clk) disable iff (!rst_b)
    output_stage_select |=> (irq_pin_a_oe_b || !irq_pin_a_o)
      && (irq_pin_b_oe_b || !irq_pin_b_o))
    else $error("open-drain pin drove high");

  open_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    output_stage_select && irq_level_polarity && pin_a_active |=> irq_pin_a_oe_b)
    else $error("open-drain active high pin not released");

  push_pull_a: assert property (@(posedge clk) disable iff (!rst_b)
    !output_stage_select |=> !irq_pin_a_oe_b && !irq_pin_b_oe_b)
    else $error("push-pull pin released");

  push_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    !output_stage_select && pin_a_active |=> irq_pin_a_o == $past(irq_level_polarity))
    else $error("push-pull pin a at wrong level");

  source_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    reg_req.addr == SOURCE_OFFSET
      |=> reg_rdata == ($past(event_flags & enables_q) & USED_BITS_MASK))
    else $error("source read mismatch");

  enables_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    reg_req.addr == ENABLES_OFFSET |=> reg_rdata == $past(enables_q))
    else $error("enable read mismatch");

  routing_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    reg_req.addr == ROUTING_OFFSET |=> reg_rdata == $past(routing_q))
    else $error("routing read mismatch");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    unmapped_read_s |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Per source checks; bit 1 has no source behind it
  for (genvar g = 0; g < 8; g++) begin : gen_src
    if (g != BIT_UNUSED) begin : gen_used
      src_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        !enables_q[g] |-> !pending[g])
        else $error("disabled source reported pending");

      src_route_a_a: assert property (@(posedge clk) disable iff (!rst_b)
        pending[g] && routing_q[g] |=> wire_a == $past(irq_level_polarity))
        else $error("source routed to pin a missing");

      src_route_b_a: assert property (@(posedge clk) disable iff (!rst_b)
        pending[g] && !routing_q[g] |=> wire_b == $past(irq_level_polarity))
        else $error("source routed to pin b missing");
    end
  end
endmodule

// >>> dv/irq_host_model.sv
// Host side model that resolves both interrupt lines
`timescale 1ns/1ps
module irq_host_model (
  input  wire logic a_o,
  input  wire logic a_oe_b,
  input  wire logic b_o,
  input  wire logic b_oe_b,
  input  wire logic pol,
  output logic      seen_a,
  output logic      seen_b
);
  // Released line floats up through the board pull-up, so open-drain needs no driver here
  assign seen_a = ((a_oe_b ? 1'b1 : a_o) === pol);
  assign seen_b = ((b_oe_b ? 1'b1 : b_o) === pol);
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the interrupt enable and routing block
`timescale 1ns/1ps
module tb_top;
  import irq_route_pkg::*;
  logic       clk = 0, rst_b = 0, ods = 0, pol = 0;
  reg_req_t   req = '0;
  logic [7:0] flags = '0, rdata, m;
  logic       ao, aoe, bo, boe, sa, sb;
  int         error_cnt = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  motion_interrupt_routing dut_u (.clk(clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
    .event_flags(flags), .output_stage_select(ods), .irq_level_polarity(pol),
    .irq_pin_a_o(ao), .irq_pin_a_oe_b(aoe), .irq_pin_b_o(bo), .irq_pin_b_oe_b(boe));
  irq_host_model host_u (.a_o(ao), .a_oe_b(aoe), .b_o(bo), .b_oe_b(boe), .pol(pol),
    .seen_a(sa), .seen_b(sb));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, a, d};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  // Read data is registered, so it is judged two edges after the address goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) req.addr <= a;
    repeat (2) @(posedge clk);
    #1 chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic test_reset;
    rd(ENABLES_OFFSET, 8'h00);
    rd(ROUTING_OFFSET, 8'h00);
    chk({6'h00, sa, sb}, 8'h00);
    $display("test_reset done");
  endtask
  task automatic test_regs;
    wr(ENABLES_OFFSET, 8'hff);
    rd(ENABLES_OFFSET, 8'hfd);
    wr(ROUTING_OFFSET, 8'hff);
    rd(ROUTING_OFFSET, 8'hfd);
    wr(8'h2f, 8'h00);
    rd(8'h2f, 8'h00);
    $display("test_regs done");
  endtask
  // One source enabled at a time while every flag is pending
  task automatic test_route;
    @(posedge clk) flags <= 8'hff;
    for (int i = 0; i < 8; i++) begin
      if (i == BIT_UNUSED) continue;
      m = 8'h01 << i;
      wr(ENABLES_OFFSET, m);
      wr(ROUTING_OFFSET, i[0] ? m : 8'h00);
      settle();
      chk({6'h00, sa, sb}, i[0] ? 8'h02 : 8'h01);
      rd(SOURCE_OFFSET, m);
    end
    @(posedge clk) flags <= 8'h00;
    settle();
    chk({6'h00, sa, sb}, 8'h00);
    $display("test_route done");
  endtask
  task automatic test_stage;
    wr(ENABLES_OFFSET, 8'h01);
    wr(ROUTING_OFFSET, 8'h01);
    @(posedge clk) flags <= 8'h01;
    settle();
    chk({4'h0, aoe, boe, ao, bo}, 8'h01);
    @(posedge clk) pol <= 1'b1;
    settle();
    chk({6'h00, ao, sa}, 8'h03);
    @(posedge clk) begin
      pol <= 1'b0;
      ods <= 1'b1;
    end
    settle();
    chk({3'h0, aoe, boe, ao, bo, sa}, 8'h09);
    @(posedge clk) pol <= 1'b1;
    settle();
    chk({3'h0, aoe, boe, ao, bo, sa}, 8'h11);
    $display("test_stage done");
  endtask
  task automatic test_midreset;
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ENABLES_OFFSET, ENABLES_RESET);
    rd(ROUTING_OFFSET, ROUTING_RESET);
    chk({6'h00, sa, sb}, 8'h00);
    $display("test_midreset done");
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    test_reset();
    test_regs();
    test_route();
    test_stage();
    test_midreset();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
